// ==== hdl/config_clock_consts.svh ====
`ifndef CONFIG_CLOCK_CONSTS_SVH
`define CONFIG_CLOCK_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define OFS_BRIDGE_CLOCK_DIVIDER 32'hBD01_0100
`define OFS_DPLL_PARAMETERS 32'hBD01_0104
`define OFS_SYSTEM_CLOCK_SETTING 32'hBD01_0108
`define OFS_MASTER_TOKEN_SETTING 32'hBD01_0110
`define OFS_BRIDGE_MASTER_WEIGHTS 32'hBD01_0114
`define OFS_PCI_MASTER_WEIGHTS 32'hBD01_0118
`define OFS_STRAP_STATUS 32'hBD01_011C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BRIDGE_CLOCK_DIVIDER 32'h0000_0511
`define RST_DPLL_PARAMETERS 32'h0003_1703
`define RST_SYSTEM_CLOCK_SETTING 32'h0000_0000
`define RST_MASTER_TOKEN_SETTING 32'h0F01_0101
`define RST_BRIDGE_MASTER_WEIGHTS 32'h1111_1111
`define RST_PCI_MASTER_WEIGHTS 32'h0000_2222

// ----------------------------------------------------------------
// Writable bit masks
// ----------------------------------------------------------------
`define WMASK_BRIDGE_DIV 32'h0000_0FFF
`define WMASK_PLL_FREE 32'h0003_4000
`define WMASK_PLL_MN 32'h0000_3F1F
`define WMASK_SYS_FREE 32'h00C0_8080
`define WMASK_SYS_CPU_CLOCK_SETTING 32'h0000_0F00
`define WMASK_SYS_MEMORY_CLOCK_SETTING 32'h0000_000F
`define WMASK_TOKENS 32'hFFFF_FFFF
`define WMASK_BRIDGE_WTS 32'hFFFF_FFFF
`define WMASK_PCI_WTS 32'h0000_FFFF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PLL_PLL_PARAM_WRITE_ENABLE_BIT 14
`define PLL_M_LSB 8
`define PLL_N_LSB 0
`define PLL_ARBWS_LSB 16
`define SYS_CPU_SETTING_WRITE_ENABLE_BIT 15
`define SYS_MEMORY_SETTING_WRITE_ENABLE_BIT 7
`define SYS_CPU_CLOCK_SETTING_LSB 8
`define SYS_MEMORY_CLOCK_SETTING_LSB 0
`define SYS_PCI_IO_MAP_SELECT_LSB 22
`define PCI_IO_MAP_32 2'h3

// ----------------------------------------------------------------
// Misc constants
// ----------------------------------------------------------------
`define STRAP_WIDTH 23
`define EXT_CLK_RATE_CODE 4'h1
`define PLL_REF_KHZ 23'h00_9C40
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hdl/config_clock_pkg.sv ====
package config_clock_pkg;

    // ------------------------------------------------------------
    // Captured strap word, bit 22 down to bit 0
    // ------------------------------------------------------------
    typedef struct packed {
        logic proc_mode_cp_test;
        logic cp_test;
        logic cpu_scan_test;
        logic ext_clk_sel;
        logic ext_grant_off;
        logic jtag_enable;
        logic pci_ad_sel;
        logic gpio_e_sel;
        logic gpio_d_sel;
        logic gpio_c_sel;
        logic gpio_b_sel;
        logic i2c_sel;
        logic pcm_sel;
        logic boot_nand;
        logic [1:0] sdram_delay;
        logic [1:0] flash_width;
        logic sdram_sync;
        logic [3:0] rate_sel;
    } strap_type;

    typedef struct packed {
        logic pcm_on_wan;
        logic i2c_on_uart0;
        logic gpio_b_on_uart0;
        logic gpio_c_on_memdata;
        logic gpio_d_on_wan;
        logic gpio_e_on_nand;
        logic gpio_f_on_pci_ad;
    } pinmux_type;

    typedef struct packed {
        logic [1:0] ptr;
        logic [7:0] credit;
        logic [3:0] grant;
    } arb_type;

    typedef enum logic [2:0] {
        REG_BDIV, REG_PLL, REG_SYS, REG_TKN,
        REG_BW, REG_PW, REG_STRAP, REG_NONE
    } reg_sel_type;

    typedef struct packed {
        logic [22:0] pin_meta;
        logic [22:0] pin_sync;
        strap_type strap;
        logic hold_meta;
        logic hold_sync;
        logic [31:0] bdiv;
        logic [31:0] pll;
        logic [31:0] sys;
        logic [31:0] tkn;
        logic [31:0] bw;
        logic [31:0] pw;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [2:0][3:0] div_cnt;
        logic [2:0] div_en;
        arb_type [3:0] arb;
    } state_type;

endpackage

// ==== hdl/system_config_clock_arbitration.sv ====
// Summary of operation
// - Strap word comes from pin levels and sets defaults with no software.
// - Strap bits 3..0 pick one of sixteen CPU and SDRAM rate pairs.
// - Strap bit 4 high makes SDRAM clock equal bus clock, low asynchronous.
// - Strap bits 6..5 give flash width 8, 16, 32 bits; 11 reserved.
// - Strap bits 8..7 give SDRAM clock delay of zero to three units.
// - Strap bit 9 boots from NOR when low, NAND when high.
// - Bits 10,11,12,13,15 switch pins when high; bit 16 low gives GPIO F.
// - Bit 14 gives GPIO D on WAN pins only when PCM is not chosen.
// - Bit 17 enables JTAG; bits 20, 21, 22 enable three test modes.
// - Bit 18 low lets an external pin control bus grant, high disables it.
// - Bit 19 picks external clock pin, effective only with rate code 0001.
// - CPU clock stays synchronous with bus clock at every rate.
// - Bus arbiter shares the bus among four masters by 8-bit tokens.
// - Three 4-bit bridge ratio fields, codes 1,3,5,7 give 2,4,6,8 to 1.
// - Each bridge arbiter weights its four masters by 4-bit fields.
// - DPLL rate is 40 MHz times (M+1)/(N+1) from the M and N fields.
// - M and N accept a write only when bit 14 of that write is high.
// - CPU setting changes only with bit 15, memory setting with bit 7.
// - Each rate code pairs with a fixed CPU and memory setting value.
// - PCI I/O map field 00 selects 16-bit, 11 selects 32-bit mapping.
//
// The AXI4-Lite register port was decided locally.
`include "config_clock_consts.svh"

module system_config_clock_arbitration import config_clock_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Strap and grant-hold pins
    input wire logic [22:0] strap_pins,
    input wire logic ext_grant_hold_pin,
    // Bus requests and grants
    input wire logic [3:0] sys_req,
    input wire logic [2:0][3:0] bridge_req,
    output logic [3:0] sys_grant,
    output logic [2:0][3:0] bridge_grant,
    output logic [2:0] bridge_clk_en,
    // Strap derived configuration
    output strap_type strap_config,
    output pinmux_type pin_function,
    output logic sys_clk_external,
    output logic [11:0] cpu_rate_tenth_mhz,
    output logic [11:0] bus_rate_tenth_mhz,
    output logic [11:0] sdram_rate_tenth_mhz,
    output logic [3:0] strap_cpu_setting,
    output logic [3:0] strap_mem_setting,
    // Register derived configuration
    output logic [5:0] pll_m_param,
    output logic [4:0] pll_n_param,
    output logic [22:0] pll_rate_khz,
    output logic [1:0] arbiter_wait,
    output logic [3:0] cpu_clock_setting,
    output logic [3:0] memory_clock_setting,
    output logic [1:0] pci_io_map_select,
    output logic pci_io_map_32
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic reg_sel_type reg_decode(logic [31:0] addr);
        unique case (addr)
            `OFS_BRIDGE_CLOCK_DIVIDER: reg_decode = REG_BDIV;
            `OFS_DPLL_PARAMETERS: reg_decode = REG_PLL;
            `OFS_SYSTEM_CLOCK_SETTING: reg_decode = REG_SYS;
            `OFS_MASTER_TOKEN_SETTING: reg_decode = REG_TKN;
            `OFS_BRIDGE_MASTER_WEIGHTS: reg_decode = REG_BW;
            `OFS_PCI_MASTER_WEIGHTS: reg_decode = REG_PW;
            `OFS_STRAP_STATUS: reg_decode = REG_STRAP;
            default: reg_decode = REG_NONE;
        endcase
    endfunction

    function automatic logic [31:0] merge(logic [31:0] old,
            logic [31:0] val, logic [31:0] m);
        merge = (old & ~m) | (val & m);
    endfunction

    // Packs {cpu setting, mem setting, cpu rate, sdram rate} per code
    function automatic logic [31:0] rate_entry(logic [3:0] code);
        unique case (code)
            4'h0: rate_entry = {4'h2, 4'h4, 12'h7D0, 12'h535};
            4'h1: rate_entry = {4'h2, 4'h4, 12'h7D0, 12'h535};
            4'h2: rate_entry = {4'h2, 4'h5, 12'h7D0, 12'h3E8};
            4'h3: rate_entry = {4'h2, 4'h5, 12'h7D0, 12'h640};
            4'h4: rate_entry = {4'h3, 4'h5, 12'h7D0, 12'h4E2};
            4'h5: rate_entry = {4'h2, 4'h4, 12'h898, 12'h5BB};
            4'h6: rate_entry = {4'h2, 4'h4, 12'h855, 12'h58E};
            4'h7: rate_entry = {4'h2, 4'h5, 12'h855, 12'h42B};
            4'h8: rate_entry = {4'h2, 4'h4, 12'h780, 12'h500};
            4'h9: rate_entry = {4'h1, 4'h3, 12'h780, 12'h480};
            4'hA: rate_entry = {4'h2, 4'h5, 12'h76C, 12'h3B6};
            4'hB: rate_entry = {4'h2, 4'h4, 12'h708, 12'h4B0};
            4'hC: rate_entry = {4'h1, 4'h4, 12'h708, 12'h384};
            4'hD: rate_entry = {4'h5, 4'h5, 12'h3E8, 12'h3E8};
            4'hE: rate_entry = {4'h4, 4'h6, 12'h3E8, 12'h1F4};
            4'hF: rate_entry = {4'h4, 4'h6, 12'h29B, 12'h14D};
        endcase
    endfunction

    // Weighted round robin step; a master keeps the bus for w grants
    function automatic arb_type arb_step(arb_type a, logic [3:0] req,
            logic [3:0][7:0] w);
        arb_type n;
        logic found;
        logic [1:0] idx;
        n = a;
        found = 1'b0;
        idx = a.ptr;
        if (a.grant != 4'h0 && req[a.ptr] && a.credit > 8'h01) begin
            n.credit = a.credit - 8'h01;
        end else begin
            n.grant = 4'h0;
            for (int i = 1; i <= 4; i++) begin
                idx = a.ptr + i[1:0];
                // Zero weight never wins
                if (!found && req[idx] && w[idx] != 8'h00) begin
                    found = 1'b1;
                    n.ptr = idx;
                    n.credit = w[idx];
                    n.grant = 4'h1 << idx;
                end
            end
        end
        return n;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    state_type s_r;
    state_type s_nxt;
    logic [31:0] wmask;
    logic [31:0] pll_mask;
    logic [31:0] sys_mask;
    reg_sel_type widx;
    reg_sel_type ridx;
    logic wr_go;
    logic rd_go;
    logic grant_blocked;
    logic [3:0][3:0][7:0] wts;
    logic [3:0][3:0] reqs;
    logic [3:0] arb_en;
    logic [31:0] rate_word;
    logic [6:0] m_plus;
    logic [5:0] n_plus;
    logic [22:0] pll_prod;

    // Writes wait for address and data together; no skid needed
    assign awready = awvalid && wvalid && !s_r.bvalid;
    assign wready = awready;
    assign wr_go = awready;
    assign arready = !s_r.rvalid;
    assign rd_go = arvalid && arready;

    assign grant_blocked = s_r.hold_sync && !s_r.strap.ext_grant_off;

    always_comb begin
        s_nxt = s_r;
        wmask = '0;
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{wstrb[b]}};
        end
        widx = reg_decode(awaddr);
        ridx = reg_decode(araddr);
        pll_mask = `WMASK_PLL_FREE
            | (wdata[`PLL_PLL_PARAM_WRITE_ENABLE_BIT] ? `WMASK_PLL_MN : 32'h0000_0000);
        sys_mask = `WMASK_SYS_FREE
            | (wdata[`SYS_CPU_SETTING_WRITE_ENABLE_BIT] ? `WMASK_SYS_CPU_CLOCK_SETTING : 32'h0000_0000)
            | (wdata[`SYS_MEMORY_SETTING_WRITE_ENABLE_BIT] ? `WMASK_SYS_MEMORY_CLOCK_SETTING : 32'h0000_0000);
        s_nxt.pin_meta = strap_pins;
        s_nxt.pin_sync = s_r.pin_meta;
        s_nxt.hold_meta = ext_grant_hold_pin;
        s_nxt.hold_sync = s_r.hold_meta;

        // Register writes
        if (wr_go) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = (widx == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            unique case (widx)
                REG_BDIV: s_nxt.bdiv = merge(s_r.bdiv, wdata,
                    wmask & `WMASK_BRIDGE_DIV);
                REG_PLL: s_nxt.pll = merge(s_r.pll, wdata, wmask & pll_mask);
                REG_SYS: s_nxt.sys = merge(s_r.sys, wdata, wmask & sys_mask);
                REG_TKN: s_nxt.tkn = merge(s_r.tkn, wdata,
                    wmask & `WMASK_TOKENS);
                REG_BW: s_nxt.bw = merge(s_r.bw, wdata,
                    wmask & `WMASK_BRIDGE_WTS);
                REG_PW: s_nxt.pw = merge(s_r.pw, wdata, wmask & `WMASK_PCI_WTS);
                REG_STRAP: ;
                REG_NONE: ;
            endcase
        end else if (s_r.bvalid && bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Register reads
        if (rd_go) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = (ridx == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            unique case (ridx)
                REG_BDIV: s_nxt.rdata = s_r.bdiv;
                REG_PLL: s_nxt.rdata = s_r.pll;
                REG_SYS: s_nxt.rdata = s_r.sys;
                REG_TKN: s_nxt.rdata = s_r.tkn;
                REG_BW: s_nxt.rdata = s_r.bw;
                REG_PW: s_nxt.rdata = s_r.pw;
                REG_STRAP: s_nxt.rdata = {9'h000, s_r.strap};
                REG_NONE: s_nxt.rdata = 32'h0000_0000;
            endcase
        end else if (s_r.rvalid && rready) begin
            s_nxt.rvalid = 1'b0;
        end

        // ------------------------------------------------------------
        // Bridge clock dividers
        // ------------------------------------------------------------
        // divide by code plus one
        for (int d = 0; d < 3; d++) begin
            if (s_r.div_cnt[d] >= s_r.bdiv[4*d +: 4]) begin
                s_nxt.div_cnt[d] = 4'h0;
                s_nxt.div_en[d] = 1'b1;
            end else begin
                s_nxt.div_cnt[d] = s_r.div_cnt[d] + 4'h1;
                s_nxt.div_en[d] = 1'b0;
            end
        end

        // ------------------------------------------------------------
        // Arbiters: 0 system, 1 bridge zero, 2 bridge one, 3 PCI
        // ------------------------------------------------------------
        // token weights
        wts[0] = {s_r.tkn[7:0], s_r.tkn[15:8], s_r.tkn[23:16],
            s_r.tkn[31:24]};
        reqs[0] = sys_req;
        arb_en[0] = 1'b1;
        for (int k = 0; k < 4; k++) begin
            wts[1][k] = {4'h0, s_r.bw[4*k +: 4]};
            wts[2][k] = {4'h0, s_r.bw[16 + 4*k +: 4]};
            wts[3][k] = {4'h0, s_r.pw[4*k +: 4]};
        end
        for (int k = 1; k < 4; k++) begin
            reqs[k] = bridge_req[k-1];
            arb_en[k] = s_r.div_en[k-1];
        end
        for (int k = 0; k < 4; k++) begin
            if (arb_en[k]) begin
                s_nxt.arb[k] = arb_step(s_r.arb[k], reqs[k], wts[k]);
            end
        end
        // hold pin parks the system bus
        if (grant_blocked) begin
            s_nxt.arb[0].grant = 4'h0;
            s_nxt.arb[0].credit = 8'h00;
        end

        if (!aresetn) begin
            s_nxt = '0;
            s_nxt.pin_meta = strap_pins;
            s_nxt.pin_sync = s_r.pin_meta;
            s_nxt.strap = s_r.pin_sync;
            s_nxt.hold_meta = ext_grant_hold_pin;
            s_nxt.hold_sync = s_r.hold_meta;
            s_nxt.bdiv = `RST_BRIDGE_CLOCK_DIVIDER;
            s_nxt.pll = `RST_DPLL_PARAMETERS;
            s_nxt.sys = `RST_SYSTEM_CLOCK_SETTING;
            s_nxt.tkn = `RST_MASTER_TOKEN_SETTING;
            s_nxt.bw = `RST_BRIDGE_MASTER_WEIGHTS;
            s_nxt.pw = `RST_PCI_MASTER_WEIGHTS;
        end
    end

    always_ff @(posedge aclk) begin
        s_r <= s_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign bvalid = s_r.bvalid;
    assign bresp = s_r.bresp;
    assign rvalid = s_r.rvalid;
    assign rresp = s_r.rresp;
    assign rdata = s_r.rdata;
    assign sys_grant = s_r.arb[0].grant;
    assign bridge_grant = {s_r.arb[3].grant, s_r.arb[2].grant,
        s_r.arb[1].grant};
    assign bridge_clk_en = s_r.div_en;
    // JTAG and test enables ride on the strap word
    assign strap_config = s_r.strap;

    assign pin_function.pcm_on_wan = s_r.strap.pcm_sel;
    assign pin_function.i2c_on_uart0 = s_r.strap.i2c_sel;
    assign pin_function.gpio_b_on_uart0 = s_r.strap.gpio_b_sel;
    assign pin_function.gpio_c_on_memdata = s_r.strap.gpio_c_sel;
    assign pin_function.gpio_d_on_wan = s_r.strap.gpio_d_sel
        && !s_r.strap.pcm_sel;
    assign pin_function.gpio_e_on_nand = s_r.strap.gpio_e_sel;
    assign pin_function.gpio_f_on_pci_ad = !s_r.strap.pci_ad_sel;

    // external clock only with code 0001
    assign sys_clk_external = s_r.strap.ext_clk_sel
        && (s_r.strap.rate_sel == `EXT_CLK_RATE_CODE);

    assign rate_word = rate_entry(s_r.strap.rate_sel);
    // CPU shares the bus clock rate
    assign cpu_rate_tenth_mhz = rate_word[23:12];
    assign bus_rate_tenth_mhz = rate_word[23:12];
    // synchronous SDRAM follows the bus clock
    assign sdram_rate_tenth_mhz = s_r.strap.sdram_sync
        ? rate_word[23:12] : rate_word[11:0];
    assign strap_cpu_setting = rate_word[31:28];
    assign strap_mem_setting = rate_word[27:24];

    // DPLL rate from M and N
    assign pll_m_param = s_r.pll[`PLL_M_LSB +: 6];
    assign pll_n_param = s_r.pll[`PLL_N_LSB +: 5];
    assign m_plus = {1'b0, pll_m_param} + 7'h01;
    assign n_plus = {1'b0, pll_n_param} + 6'h01;
    assign pll_prod = `PLL_REF_KHZ * {16'h0000, m_plus};
    assign pll_rate_khz = pll_prod / {17'h0_0000, n_plus};
    assign arbiter_wait = s_r.pll[`PLL_ARBWS_LSB +: 2];

    assign cpu_clock_setting = s_r.sys[`SYS_CPU_CLOCK_SETTING_LSB +: 4];
    assign memory_clock_setting = s_r.sys[`SYS_MEMORY_CLOCK_SETTING_LSB +: 4];
    assign pci_io_map_select = s_r.sys[`SYS_PCI_IO_MAP_SELECT_LSB +: 2];
    assign pci_io_map_32 = (pci_io_map_select == `PCI_IO_MAP_32);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_STRAP_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> $stable(strap_config))
        else $error("strap word changed after reset");

    AST_EXT_CLK_CODE: assert property (@(posedge aclk) disable iff (!aresetn)
        strap_config.rate_sel != 4'h1 |-> !sys_clk_external)
        else $error("external clock without code 0001");

    AST_GPIO_D_PCM: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_function.gpio_d_on_wan |-> !pin_function.pcm_on_wan)
        else $error("GPIO D chosen with PCM");

    AST_MN_LOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && widx == REG_PLL && !wdata[14])
        |=> $stable(pll_m_param) && $stable(pll_n_param))
        else $error("M or N changed without write enable");

    AST_CPU_CLOCK_SETTING_LOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_go && widx == REG_SYS && !wdata[15])
        |=> $stable(cpu_clock_setting))
        else $error("CPU setting changed without enable");

    AST_ZERO_WEIGHT: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(bridge_grant[0][0]) |-> $past(s_r.bw[3:0]) != 4'h0)
        else $error("zero weight master granted");

    AST_DIV_TWO: assert property (@(posedge aclk) disable iff (!aresetn)
        (bridge_clk_en[0] && s_r.bdiv[3:0] == 4'h1)
        ##1 (s_r.bdiv[3:0] == 4'h1)
        |-> !bridge_clk_en[0] ##1 bridge_clk_en[0])
        else $error("2:1 bridge enable period wrong");

    AST_GRANT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        grant_blocked |=> sys_grant == 4'h0)
        else $error("grant issued while held externally");

    AST_SETTING_PAIR: assert property (@(posedge aclk) disable iff (!aresetn)
        strap_config.rate_sel == 4'hF
        |-> strap_cpu_setting == 4'h4 && strap_mem_setting == 4'h6)
        else $error("setting pair for code 1111 wrong");

endmodule // system_config_clock_arbitration

// ==== verif/bus_masters.sv ====
// ------------------------------------------------
// Bus masters standing on the arbiter side
// ------------------------------------------------
module bus_masters (
    // Clock and control
    input wire logic aclk,
    input wire logic cpu_on,
    // Requests toward the arbiters
    output logic [3:0] sys_req,
    output logic [2:0][3:0] bridge_req
);
    timeunit 1ns;
    timeprecision 1ns;
    // Requests are levels held until dropped, never one-cycle blips
    always @(posedge aclk) begin
        sys_req <= {3'h0, cpu_on};
        bridge_req <= {3{4'h1}};
    end
endmodule // bus_masters

// ==== verif/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic hold = 1'b0, cpu_on = 1'b0, sys_ext, pci32;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r, aw, pio;
    logic [6:0] pf;
    logic [5:0] pm;
    logic [4:0] pn;
    logic [2:0] ben;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
    logic [22:0] pins = 23'h09_0001, scfg, pll_rate;
    logic [3:0] sys_req, sys_grant, cset, mset, ccs, mcs;
    logic [2:0][3:0] breq;
    logic [11:0] bus_rate, sd_rate, cpu_rate, bgr;
    int fails = 0, n_checks = 0, cnt0 = 0, cnt2 = 0;
    logic [31:0] rows [7][2] = '{'{32'hBD01_0100, 32'h0000_0511},
        '{32'hBD01_0104, 32'h0003_1703}, '{32'hBD01_0108, 32'h0000_0000},
        '{32'hBD01_0110, 32'h0F01_0101}, '{32'hBD01_0114, 32'h1111_1111},
        '{32'hBD01_0118, 32'h0000_2222}, '{32'hBD01_011C, 32'h0009_0001}};
    always #20 aclk = ~aclk;
    bus_masters i_masters (.aclk(aclk), .cpu_on(cpu_on), .sys_req(sys_req),
        .bridge_req(breq));
    system_config_clock_arbitration i_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .strap_pins(pins),
        .ext_grant_hold_pin(hold), .sys_req(sys_req), .bridge_req(breq),
        .sys_grant(sys_grant), .bridge_grant(bgr), .bridge_clk_en(ben),
        .strap_config(scfg), .pin_function(pf), .sys_clk_external(sys_ext),
        .cpu_rate_tenth_mhz(cpu_rate), .bus_rate_tenth_mhz(bus_rate),
        .sdram_rate_tenth_mhz(sd_rate), .strap_cpu_setting(cset),
        .strap_mem_setting(mset), .pll_m_param(pm), .pll_n_param(pn),
        .pll_rate_khz(pll_rate), .arbiter_wait(aw), .cpu_clock_setting(ccs),
        .memory_clock_setting(mcs), .pci_io_map_select(pio),
        .pci_io_map_32(pci32));
    // ------------------------------------------------
    // Report and bus tasks
    // ------------------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] e, s, input string n);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // Ready and valid are sampled 1 ns after the rising edge, stable until the next edge
    task wait_hi(input int w);
        int k;
        k = 0;
        #1;
        while ((w == 0 ? awready : w == 1 ? bvalid : w == 2 ? arready
                : rvalid) !== 1'b1) begin
            k++;
            if (k > 100) begin
                fails++;
                print_verdict();
            end
            @(posedge aclk);
            #1;
        end
    endtask
    task wr(input logic [31:0] a, v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        wait_hi(0);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wait_hi(1);
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task rd(input logic [31:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wait_hi(2);
        @(posedge aclk);
        arvalid <= 1'b0;
        wait_hi(3);
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        pins <= 23'h00_0000;
        for (int i = 0; i < 7; i++) begin
            rd(rows[i][0]);
            chk(rows[i][1], d, "register");
        end
        chk(32'h241, {20'h0, cset, mset, 3'h0, sys_ext}, "pair");
        chk(32'h007D_0535, {8'h0, bus_rate, sd_rate}, "rate");
        chk(32'h0009_0001, {9'h0, scfg}, "strap");
        chk(32'h0, {25'h0, pf}, "pin_function");
        chk(32'h1AE3, {19'h0, aw, pm, pn}, "pll_fields");
        chk(32'h111, {20'h0, bgr}, "bridge_grant");
        wr(32'hBD01_0104, 32'h0000_0A05);
        rd(32'hBD01_0104);
        chk(32'h0000_1703, d, "pll_locked");
        wr(32'hBD01_0104, 32'h0000_4A05);
        rd(32'hBD01_0104);
        chk(32'h0000_4A05, d, "pll_open");
        chk(32'h0001_1E75, {9'h0, pll_rate}, "pll_rate");
        wr(32'hBD01_0108, 32'h00C0_0F0F);
        rd(32'hBD01_0108);
        chk(32'h00C0_0000, d, "sys_locked");
        chk(32'h7, {29'h0, pci32, pio}, "pci_map");
        wr(32'hBD01_0108, 32'h0000_8F8F);
        rd(32'hBD01_0108);
        chk(32'h0000_8F8F, d, "sys_open");
        chk(32'hFF0, {20'h0, ccs, mcs, 1'b0, pci32, pio}, "clk_set");
        rd(32'hBD01_010C);
        chk(32'h2, {30'h0, r}, "unmapped");
        // Only listed even divide codes are written
        wr(32'hBD01_0100, 32'h0000_0733);
        repeat (8) begin
            @(negedge aclk);
            cnt0 += ben[0];
            cnt2 += ben[2];
        end
        chk(32'h0201, {16'h0, cnt0[7:0], cnt2[7:0]}, "divider");
        wr(32'hBD01_0114, 32'h1111_1132);
        rd(32'hBD01_0114);
        chk(32'h1111_1132, d, "weights");
        cpu_on <= 1'b1;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        chk(32'h1, {28'h0, sys_grant}, "grant");
        @(posedge aclk);
        hold <= 1'b1;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        chk(32'h0, {28'h0, sys_grant}, "hold");
        // Second reset with a different strap word
        @(posedge aclk);
        aresetn <= 1'b0;
        pins <= 23'h0E_47DF;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        pins <= 23'h00_0000;
        rd(32'hBD01_0108);
        chk(32'h0, d, "sys_reset");
        chk(32'h000E_47DF, {9'h0, scfg}, "strap2");
        chk(32'h460, {20'h0, cset, mset, 3'h0, sys_ext}, "pair2");
        chk(32'h0029_B29B, {8'h0, cpu_rate, sd_rate}, "rate2");
        chk(32'h41, {25'h0, pf}, "pin_function2");
        chk(32'h1, {28'h0, sys_grant}, "no_hold");
        print_verdict();
    end
endmodule // testbench
